// ==== rtl/rsc_regbank.sv ====
/*
 * Per-channel range registers and command read-back register behind a serial slave.
 * Assumes cs_n_i, sclk_i and sdi_i come from another domain and are far slower than ref_clk_i.
 */
`timescale 1ns/10ps

// What this block does
// R01: Range register bits 7-4 read zero; host must write zeros there.
// R02: Low four bits decode to five bipolar or unipolar input ranges.
// R03: Read-back returns the command executed in the preceding frame.
// R04: Read-back data starts at 16th falling SCLK edge, MSB first.
// R05: First eight output bits carry the addressed register (zeros after a write); next eight are zeros.
// R06: Host may end a read-back frame after the 24th SCLK.
// R07: Read-back is 8-bit read-only upper command byte, resets to zero.
// R08: Every range register resets to code zero, the widest bipolar range.
module rsc_regbank
	import rsc_pkg::*;
#(
	parameter int unsigned NUM_CH = 8
) (
	// Clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	// Serial link from host
	input  wire logic                  cs_n_i,
	input  wire logic                  sclk_i,
	input  wire logic                  sdi_i,
	output logic                       sdo_o,
	output logic                       sdo_oe_o,
	// Range configuration to the analog front end
	output logic [NUM_CH-1:0][3:0]     range_code_o,
	output rsc_range_t [NUM_CH-1:0]    range_cfg_o,
	// Last executed command byte
	output logic [7:0]                 readback_o
);

	// Input synchronisers
	logic [1:0] cs_n_sync;
	logic [1:0] sclk_sync;
	logic [1:0] sdi_sync;
	logic       sclk_prev;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_n_sync <= 2'h3;
			sclk_sync <= 2'h0;
			sdi_sync  <= 2'h0;
			sclk_prev <= 1'b0;
		end else begin
			cs_n_sync <= {cs_n_sync[0], cs_n_i};
			sclk_sync <= {sclk_sync[0], sclk_i};
			sdi_sync  <= {sdi_sync[0], sdi_i};
			sclk_prev <= sclk_sync[1];
		end
	end

	logic cs_n_s;
	logic sdi_s;
	logic sclk_rise;
	logic sclk_fall;

	assign cs_n_s    = cs_n_sync[1];
	assign sdi_s     = sdi_sync[1];
	assign sclk_rise = sclk_sync[1] & ~sclk_prev;
	assign sclk_fall = ~sclk_sync[1] & sclk_prev;

	// Frame and register state
	rsc_state_t            state;
	rsc_state_t            next_state;
	logic [CNT_W-1:0]      rise_cnt;
	logic [CNT_W-1:0]      next_rise_cnt;
	logic [CNT_W-1:0]      fall_cnt;
	logic [CNT_W-1:0]      next_fall_cnt;
	logic [CMD_BITS-1:0]   cmd_sh;
	logic [CMD_BITS-1:0]   next_cmd_sh;
	logic [CMD_BITS-1:0]   out_sh;
	logic [CMD_BITS-1:0]   next_out_sh;
	logic [7:0]            prev_cmd;
	logic [7:0]            next_prev_cmd;
	logic [NUM_CH-1:0][3:0] ranges;
	logic [NUM_CH-1:0][3:0] next_ranges;
	logic                  next_sdo;
	logic                  next_sdo_oe;
	logic [CMD_BITS-1:0]   word;
	logic [6:0]            addr;
	logic [7:0]            rd_byte;

	assign word = {cmd_sh[CMD_BITS-2:0], sdi_s};
	assign addr = word[ADDR_MSB:ADDR_LSB];

	always_comb begin
		next_state    = state;
		next_rise_cnt = rise_cnt;
		next_fall_cnt = fall_cnt;
		next_cmd_sh   = cmd_sh;
		next_out_sh   = out_sh;
		next_prev_cmd = prev_cmd;
		next_ranges   = ranges;
		next_sdo      = sdo_o;
		next_sdo_oe   = 1'b1;
		rd_byte       = PAD_BYTE;
		// Address decode of the completed command word
		if (addr == ADDR_READBACK) begin
			rd_byte = prev_cmd; // [R03] [R07]
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (addr == ADDR_RANGE_BASE + 7'(i)) begin
					rd_byte = {RSVD_BITS, ranges[i]}; // [R01]
				end
			end
		end
		case (state)
			ST_IDLE: begin
				next_sdo    = 1'b0;
				next_sdo_oe = 1'b0;
				if (!cs_n_s) begin
					next_state    = ST_CMD;
					next_rise_cnt = '0;
					next_fall_cnt = '0;
					next_cmd_sh   = '0;
					next_out_sh   = '0;
					next_sdo_oe   = 1'b1;
				end
			end
			ST_CMD, ST_DATA: begin
				if (sclk_rise && rise_cnt < CNT_W'(CMD_BITS)) begin
					next_cmd_sh   = word;
					next_rise_cnt = rise_cnt + 1'b1;
					if (rise_cnt == CNT_W'(CMD_BITS - 1)) begin
						next_state = ST_DATA;
						// Answer: one byte then a zero byte
						next_out_sh = {rd_byte, PAD_BYTE}; // [R05]
						if (word[WR_BIT]) begin
							next_out_sh = '0;
							for (int i = 0; i < NUM_CH; i++) begin
								if (addr == ADDR_RANGE_BASE + 7'(i)) begin
									next_ranges[i] = word[3:0]; // [R01]
								end
							end
						end
					end
				end
				if (sclk_fall) begin
					if (fall_cnt != CNT_MAX) begin
						next_fall_cnt = fall_cnt + 1'b1;
					end
					// Output from the 16th falling edge on, zero-filled afterwards
					if (state == ST_DATA && fall_cnt >= CNT_W'(SDO_START_FALL - 1)) begin
						next_sdo    = out_sh[CMD_BITS-1]; // [R04]
						next_out_sh = {out_sh[CMD_BITS-2:0], 1'b0}; // [R05]
					end
				end
				if (cs_n_s) begin
					// Early release is fine; only complete commands count
					next_state  = ST_IDLE; // [R06]
					next_sdo    = 1'b0;
					next_sdo_oe = 1'b0;
					if (state == ST_DATA) begin
						next_prev_cmd = cmd_sh[CMD_BITS-1:8]; // [R03] [R07]
					end
				end
			end
			default: begin
				next_state  = ST_IDLE;
				next_sdo    = 1'b0;
				next_sdo_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state    <= ST_IDLE;
			rise_cnt <= '0;
			fall_cnt <= '0;
			cmd_sh   <= '0;
			out_sh   <= '0;
			prev_cmd <= READBACK_RST; // [R07]
			ranges   <= {NUM_CH{RANGE_RST}}; // [R08]
			sdo_o    <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else begin
			state    <= next_state;
			rise_cnt <= next_rise_cnt;
			fall_cnt <= next_fall_cnt;
			cmd_sh   <= next_cmd_sh;
			out_sh   <= next_out_sh;
			prev_cmd <= next_prev_cmd;
			ranges   <= next_ranges;
			sdo_o    <= next_sdo;
			sdo_oe_o <= next_sdo_oe;
		end
	end

	// Registered copies so every output leaves a flip-flop
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			readback_o <= READBACK_RST;
		end else begin
			readback_o <= prev_cmd;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			rsc_range_t dec;

			rsc_range_decode u_dec (
				.code_i  (ranges[g]),
				.range_o (dec)
			);

			always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					range_code_o[g] <= RANGE_RST; // [R08]
					range_cfg_o[g]  <= RANGE_CFG_RST; // [R08]
				end else begin
					range_code_o[g] <= ranges[g];
					range_cfg_o[g]  <= dec; // [R02]
				end
			end
		end
	endgenerate

endmodule : rsc_regbank

// ==== rtl/rsc_pkg.sv ====
/*
 * Constants and types shared by the range-select and command read-back block.
 * Assumes a serial frame of at least 16 SCLK cycles framed by an active-low chip select.
 */
package rsc_pkg;

	// Serial frame layout: command word in, answer out
	localparam int unsigned CMD_BITS       = 16;
	localparam int unsigned SDO_START_FALL = 16;
	localparam int unsigned ADDR_MSB       = 15;
	localparam int unsigned ADDR_LSB       = 9;
	localparam int unsigned WR_BIT         = 8;
	localparam int unsigned CNT_W          = 5;
	localparam logic [4:0]  CNT_MAX        = 5'h1F;

	// Register addresses
	localparam logic [6:0] ADDR_RANGE_BASE = 7'h05;
	localparam logic [6:0] ADDR_READBACK   = 7'h3F;

	// Reset values
	localparam logic [3:0]  RANGE_RST    = 4'h0;
	localparam logic [7:0]  READBACK_RST = 8'h00;
	localparam logic [3:0]  RSVD_BITS    = 4'h0;
	localparam logic [7:0]  PAD_BYTE     = 8'h00;

	// Range codes
	localparam logic [3:0] CODE_BIP_2P5   = 4'h0;
	localparam logic [3:0] CODE_BIP_1P25  = 4'h1;
	localparam logic [3:0] CODE_BIP_0P625 = 4'h2;
	localparam logic [3:0] CODE_UNI_2P5   = 4'h5;
	localparam logic [3:0] CODE_UNI_1P25  = 4'h6;

	// Scale field of the decoded range
	localparam logic [1:0] SCALE_2P5   = 2'h0;
	localparam logic [1:0] SCALE_1P25  = 2'h1;
	localparam logic [1:0] SCALE_0P625 = 2'h2;

	typedef struct packed {
		logic       valid;
		logic       unipolar;
		logic [1:0] scale;
	} rsc_range_t;

	// Decoded form of the reset code: widest bipolar range
	localparam rsc_range_t RANGE_CFG_RST = '{valid: 1'b1, unipolar: 1'b0, scale: SCALE_2P5};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CMD  = 3'b010,
		ST_DATA = 3'b100
	} rsc_state_t;

endpackage : rsc_pkg

// ==== rtl/rsc_range_decode.sv ====
/*
 * Decodes one channel's 4-bit range code into polarity and scale.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/10ps

module rsc_range_decode
	import rsc_pkg::*;
(
	// Code in
	input  wire logic [3:0] code_i,
	// Decoded range out
	output rsc_range_t      range_o
);

	always_comb begin
		range_o = '0;
		case (code_i) // [R02]
			CODE_BIP_2P5: begin
				range_o.valid = 1'b1;
				range_o.scale = SCALE_2P5;
			end
			CODE_BIP_1P25: begin
				range_o.valid = 1'b1;
				range_o.scale = SCALE_1P25;
			end
			CODE_BIP_0P625: begin
				range_o.valid = 1'b1;
				range_o.scale = SCALE_0P625;
			end
			CODE_UNI_2P5: begin
				range_o.valid    = 1'b1;
				range_o.unipolar = 1'b1;
				range_o.scale    = SCALE_2P5;
			end
			CODE_UNI_1P25: begin
				range_o.valid    = 1'b1;
				range_o.unipolar = 1'b1;
				range_o.scale    = SCALE_1P25;
			end
			// Unlisted codes flag as invalid
			default: range_o = '0;
		endcase
	end

endmodule : rsc_range_decode

// ==== test/rsc_regbank_checker.sv ====
/* Assertions on the range and read-back register block.
 * Sees only the block's ports; bound to it at the foot. */
`timescale 1ns/10ps
module rsc_regbank_checker
	import rsc_pkg::*;
#(
	parameter int unsigned NUM_CH = 8
) (
	// Clock and reset
	input wire logic                    ref_clk_i,
	input wire logic                    rst_n_i,
	// Serial link
	input wire logic                    cs_n_i,
	input wire logic                    sdo_o,
	input wire logic                    sdo_oe_o,
	// Register outputs
	input wire logic [NUM_CH-1:0][3:0]  range_code_o,
	input wire rsc_range_t [NUM_CH-1:0] range_cfg_o,
	input wire logic [7:0]              readback_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_dec_wide: assert property (range_code_o[0] == 4'h0 |-> range_cfg_o[0] == 4'h8)
		else $error("code 0 decode wrong");
	a_dec_narrow: assert property (range_code_o[0] == 4'h2 |-> range_cfg_o[0] == 4'hA)
		else $error("code 2 decode wrong");
	a_dec_uni_wide: assert property (range_code_o[0] == 4'h5 |-> range_cfg_o[0] == 4'hC)
		else $error("code 5 decode wrong");
	a_dec_uni_half: assert property (range_code_o[0] == 4'h6 |-> range_cfg_o[0] == 4'hD)
		else $error("code 6 decode wrong");
	a_sdo_quiet: assert property (cs_n_i [*6] |-> !sdo_oe_o && !sdo_o)
		else $error("output active outside frame");
	a_sdo_enabled: assert property (!cs_n_i [*6] |-> sdo_oe_o)
		else $error("output not enabled in frame");
	a_readback_hold: assert property (cs_n_i [*8] |=> $stable(readback_o))
		else $error("readback moved between frames");
	a_reset_values: assert property ($rose(rst_n_i) |-> readback_o == 8'h00 && range_code_o == '0)
		else $error("reset values wrong");
	cover property (!cs_n_i [*8] ##1 cs_n_i);
	cover property ($changed(readback_o));
	cover property (range_cfg_o[0].unipolar);
endmodule : rsc_regbank_checker

bind rsc_regbank rsc_regbank_checker #(.NUM_CH(NUM_CH)) i_chk (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
	.range_code_o(range_code_o), .range_cfg_o(range_cfg_o), .readback_o(readback_o));

// ==== test/rsc_host_model.sv ====
/* Host side of the serial link: frames of n SCLK cycles, 80 ns each.
 * Assumes a free-running reference clock at 100 MHz. */
`timescale 1ns/10ps
module rsc_host_model (
	// Reference timing
	input wire logic clk_i,
	// Serial link
	output logic     cs_n_o,
	output logic     sclk_o,
	output logic     sdi_o,
	input wire logic sdo_i
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o  = 1'b0;
	end
	// SCLK stands low between frames; SDI toggles once unused
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
		rx = '0;
		@(negedge clk_i) cs_n_o = 1'b0;
		for (int i = 1; i <= n; i++) begin
			sdi_o = (i <= 16) ? w[16-i] : ~sdi_o;
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b1;
			repeat (4) @(negedge clk_i);
			if (i > 16)
				rx[32-i] = sdo_i;
			sclk_o = 1'b0;
		end
		repeat (4) @(negedge clk_i);
		cs_n_o = 1'b1;
		sdi_o  = ~sdi_o;
		repeat (8) @(negedge clk_i);
	endtask : xfer
endmodule : rsc_host_model

// ==== test/rsc_regbank_tb_top.sv ====
/* Self-checking bench for the range and read-back register block.
 * Drives the link through the host model, random codes from a fixed seed. */
`timescale 1ns/10ps
module rsc_regbank_tb_top;
	import rsc_pkg::*;
	logic             ref_clk_i, rst_n_i, cs_n, sclk, sdi, sdo, sdo_oe;
	logic [7:0][3:0]  code_o;
	rsc_range_t [7:0] cfg_o;
	logic [7:0]       rb_o;
	logic [15:0]      rx;
	logic [3:0]       c;
	logic [6:0]       a;
	int               error_cnt = 0, tests_run = 0, ch, k;
	integer           seed = 32'hf5aee63b;
	logic [3:0]       codes [5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6};

	rsc_regbank #(.NUM_CH(8)) i_dut (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
		.sdo_o(sdo), .sdo_oe_o(sdo_oe), .range_code_o(code_o), .range_cfg_o(cfg_o), .readback_o(rb_o));
	rsc_host_model i_host (.clk_i(ref_clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	function automatic rsc_range_t dec(input logic [3:0] x);
		dec = '{valid: (x < 3 || x == 5 || x == 6), unipolar: x[2], scale: (x == 2) ? 2'h2 : {1'b0, x[0] ^ x[2]}};
	endfunction : dec

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Hang guard
	initial begin
		#500000;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		rst_n_i = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		i_host.xfer(16'h7E00, 32, rx);
		check(rx, 16'h0000);
		for (ch = 0; ch < 8; ch++) begin
			i_host.xfer({ADDR_RANGE_BASE + 7'(ch), 9'h000}, 32, rx);
			check(rx, 16'h0000);
		end
		$display("test done: reset values");
		for (k = 0; k < 12; k++) begin
			c = (k < 5) ? codes[k] : codes[$unsigned($random(seed)) % 5];
			ch = $unsigned($random(seed)) % 8;
			a = ADDR_RANGE_BASE + 7'(ch);
			i_host.xfer({a, 1'b1, 4'h0, c}, 24, rx);
			check(rx, 16'h0000);
			check(code_o[ch], c);
			check(cfg_o[ch], dec(c));
			i_host.xfer({a, 9'h000}, 32, rx);
			check(rx, {4'h0, c, 8'h00});
			i_host.xfer(16'h7E00, 24, rx);
			check(rx[15:8], {a, 1'b0});
			check(rb_o, 8'h7E);
		end
		$display("test done: range codes and readback");
		// Mid-run reset brings every register back
		@(negedge ref_clk_i) rst_n_i = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		check(rb_o, 8'h00);
		for (ch = 0; ch < 8; ch++) begin
			check(code_o[ch], 4'h0);
			check(cfg_o[ch], dec(4'h0));
		end
		i_host.xfer(16'h7E00, 24, rx);
		check(rx, 16'h0000);
		$display("test done: mid-run reset");
		// Every defined code through channel 0
		for (k = 0; k < 5; k++) begin
			i_host.xfer({ADDR_RANGE_BASE, 1'b1, 4'h0, codes[k]}, 24, rx);
			check(code_o[0], codes[k]);
		end
		i_host.xfer(16'h7E00, 24, rx);
		check(rx[15:8], {ADDR_RANGE_BASE, 1'b1});
		$display("test done: channel 0 sweep");
		// Aborted frame must not execute nor become the previous command
		i_host.xfer(16'h0B05, 8, rx);
		check(code_o[0], codes[4]);
		i_host.xfer(16'h7E00, 24, rx);
		check(rx[15:8], 8'h7E);
		$display("test done: aborted frame");
		report_and_stop();
	end
endmodule : rsc_regbank_tb_top
